// File: src/lut_distributed_ram.sv
// logic_cell lookup table ram: split, combined, dual-port and ram-plus-logic organisations
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module lut_distributed_ram
    import lut_ram_pkg::*;
(
    input  wire logic                               i_clk,
    input  wire logic                               i_srst,
    input  wire logic                               i_ce,
    input  wire lut_ram_pkg::ram_org_t              i_org,
    input  wire logic                               i_async,
    input  wire logic                               i_wclk_invert,
    input  wire logic                               i_wclk,
    input  wire logic                               i_we,
    input  wire logic [lut_ram_pkg::ADDR_W-1:0]     i_addr_f,
    input  wire logic [lut_ram_pkg::ADDR_W-1:0]     i_addr_g,
    input  wire logic [lut_ram_pkg::ADDR_W-1:0]     i_second_read_address,
    input  wire logic                               i_primary_data_in,
    input  wire logic                               i_secondary_data_in,
    input  wire logic [lut_ram_pkg::LOGIC_IN_W-1:0] i_logic_inputs,
    input  wire logic [lut_ram_pkg::LOGIC_TAB_W-1:0] i_logic_table,
    output logic                                    o_first_read_output,
    output logic                                    o_second_read_output
);
    import lut_ram_pkg::*;

    // write clock pin synchroniser; stage one feeds stage two only
    logic wclk_s1_q;
    logic wclk_s2_q;
    logic wclk_s3_q;
    logic wclk_s1_d;
    logic wclk_s2_d;
    logic wclk_s3_d;

    always_comb begin
        wclk_s1_d = wclk_s1_q;
        wclk_s2_d = wclk_s2_q;
        wclk_s3_d = wclk_s3_q;
        if (i_ce) begin
            wclk_s1_d = i_wclk;
            wclk_s2_d = wclk_s1_q;
            wclk_s3_d = wclk_s2_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wclk_s1_q <= WCLK_RST_VAL;
            wclk_s2_q <= WCLK_RST_VAL;
            wclk_s3_q <= WCLK_RST_VAL;
        end else begin
            wclk_s1_q <= wclk_s1_d;
            wclk_s2_q <= wclk_s2_d;
            wclk_s3_q <= wclk_s3_d;
        end
    end

    logic edge_hit;
    logic async_eff;
    logic wr_strobe;
    logic f_rdata;
    logic g_rdata;
    logic logic_out;
    table_wr_t wr_f;
    table_wr_t wr_g;
    logic [ADDR_W-1:0] raddr_f;
    logic [ADDR_W-1:0] raddr_g;

    // inversion of the write clock is its own option, not tied to the cell flip-flops
    assign edge_hit = i_wclk_invert ? (wclk_s3_q & ~wclk_s2_q) : (wclk_s2_q & ~wclk_s3_q);

    // dual-port has no level-sensitive option, so the async setting is ignored there
    assign async_eff = i_async && (i_org != org_dual);

    // one strobe for the whole cell, so both tables always share a timing mode
    assign wr_strobe = async_eff ? i_we : (i_we && edge_hit);

    // five-input function generator from the i_logic_table input
    assign logic_out = i_logic_table[i_logic_inputs];

    always_comb begin
        wr_f    = '{en: 1'h0, addr: i_addr_f, data: i_primary_data_in};
        wr_g    = '{en: 1'h0, addr: i_addr_g, data: i_secondary_data_in};
        raddr_f = i_addr_f;
        raddr_g = i_addr_g;
        case (i_org)
            org_split: begin
                wr_f.en = wr_strobe;
                wr_g.en = wr_strobe;
            end
            org_combined: begin
                wr_g.addr = i_addr_f;
                wr_g.data = i_primary_data_in;
                raddr_g   = i_addr_f;
                wr_f.en   = wr_strobe && !i_secondary_data_in;
                wr_g.en   = wr_strobe && i_secondary_data_in;
            end
            org_dual: begin
                wr_g.addr = i_addr_f;
                wr_g.data = i_primary_data_in;
                raddr_g   = i_second_read_address;
                wr_f.en   = wr_strobe;
                wr_g.en   = wr_strobe;
            end
            org_ram_logic: begin
                wr_f.en = wr_strobe;
            end
            default: begin
                wr_f.en = 1'h0;
                wr_g.en = 1'h0;
            end
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_table
            logic      rd;
            table_wr_t wr;
            logic [ADDR_W-1:0] ra;
            assign wr = (gi == 0) ? wr_f : wr_g;
            assign ra = (gi == 0) ? raddr_f : raddr_g;
            lut_table_mem u_mem (
                .i_clk   (i_clk),
                .i_srst  (i_srst),
                .i_ce    (i_ce),
                .i_wr    (wr),
                .i_raddr (ra),
                .o_rdata (rd)
            );
        end
    endgenerate

    assign f_rdata = g_table[0].rd;
    assign g_rdata = g_table[1].rd;

    // outputs are straight lookups; a write shows on the read one cycle after its strobe
    always_comb begin
        o_first_read_output  = f_rdata;
        o_second_read_output = g_rdata;
        case (i_org)
            org_combined: begin
                o_first_read_output  = i_secondary_data_in ? g_rdata : f_rdata;
                o_second_read_output = 1'h0;
            end
            org_ram_logic: begin
                o_second_read_output = logic_out;
            end
            default: begin
                o_first_read_output  = f_rdata;
                o_second_read_output = g_rdata;
            end
        endcase
    end

    // checks
    property p_sync_write_on_edge;
        @(posedge i_clk) disable iff (i_srst)
        (!async_eff && (wr_f.en || wr_g.en)) |-> (i_we && edge_hit);
    endproperty
    a_sync_write_on_edge: assert property (p_sync_write_on_edge) else $error("sync write without edge");

    property p_async_level_write;
        @(posedge i_clk) disable iff (i_srst)
        (i_org == org_split && i_async && i_we) |-> (wr_f.en && wr_g.en);
    endproperty
    a_async_level_write: assert property (p_async_level_write) else $error("async write missed");

    property p_shared_timing;
        @(posedge i_clk) disable iff (i_srst)
        (i_org == org_split || i_org == org_dual) |-> (wr_f.en == wr_g.en);
    endproperty
    a_shared_timing: assert property (p_shared_timing) else $error("tables differ in write timing");

    property p_split_readback;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_split && wr_f.en) ##1 (i_org == org_split && i_addr_f == $past(i_addr_f))
            |-> o_first_read_output == $past(i_primary_data_in);
    endproperty
    a_split_readback: assert property (p_split_readback) else $error("split readback wrong");

    property p_combined_bank;
        @(posedge i_clk) disable iff (i_srst)
        (i_org == org_combined) |-> (!(wr_f.en && wr_g.en) && (!wr_g.en || i_secondary_data_in));
    endproperty
    a_combined_bank: assert property (p_combined_bank) else $error("combined bank select wrong");

    property p_dual_no_async;
        @(posedge i_clk) disable iff (i_srst)
        (i_org == org_dual && i_async && i_we && !edge_hit) |-> !wr_f.en;
    endproperty
    a_dual_no_async: assert property (p_dual_no_async) else $error("dual wrote without edge");

    property p_dual_second_read;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_dual && wr_f.en) ##1
            (i_org == org_dual && i_second_read_address == $past(i_addr_f))
            |-> o_second_read_output == $past(i_primary_data_in);
    endproperty
    a_dual_second_read: assert property (p_dual_second_read) else $error("second port readback wrong");

    property p_edge_polarity;
        @(posedge i_clk) disable iff (i_srst)
        (!async_eff && wr_f.en) |-> (wclk_s2_q == !i_wclk_invert) && (wclk_s3_q == i_wclk_invert);
    endproperty
    a_edge_polarity: assert property (p_edge_polarity) else $error("write on wrong clock edge");

    property p_logic_beside_ram;
        @(posedge i_clk) disable iff (i_srst)
        (i_org == org_ram_logic) |-> (!wr_g.en && o_second_read_output == i_logic_table[i_logic_inputs]);
    endproperty
    a_logic_beside_ram: assert property (p_logic_beside_ram) else $error("logic function wrong");

    property p_split_g_readback;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_split && wr_g.en) ##1 (i_org == org_split && i_addr_g == $past(i_addr_g))
            |-> o_second_read_output == $past(i_secondary_data_in);
    endproperty
    a_split_g_readback: assert property (p_split_g_readback) else $error("table g readback wrong");

    property p_combined_readback;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_combined && (wr_f.en || wr_g.en)) ##1
            (i_org == org_combined && i_addr_f == $past(i_addr_f)
             && i_secondary_data_in == $past(i_secondary_data_in))
            |-> o_first_read_output == $past(i_primary_data_in);
    endproperty
    a_combined_readback: assert property (p_combined_readback) else $error("combined readback wrong");

    property p_combined_second_low;
        @(posedge i_clk) disable iff (i_srst)
        (i_org == org_combined) |-> (o_second_read_output == 1'h0);
    endproperty
    a_combined_second_low: assert property (p_combined_second_low) else $error("second output set");

    property p_dual_first_read;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_dual && wr_f.en) ##1 (i_org == org_dual && i_addr_f == $past(i_addr_f))
            |-> o_first_read_output == $past(i_primary_data_in);
    endproperty
    a_dual_first_read: assert property (p_dual_first_read) else $error("first port readback wrong");

    // a write elsewhere must leave the word under the second port alone
    property p_dual_read_undisturbed;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_dual && wr_f.en) ##1
            (i_org == org_dual && i_second_read_address != $past(i_addr_f) && $stable(i_second_read_address))
            |-> $stable(o_second_read_output);
    endproperty
    a_dual_read_undisturbed: assert property (p_dual_read_undisturbed) else $error("second port disturbed");

    property p_async_we_low;
        @(posedge i_clk) disable iff (i_srst)
        (async_eff && !i_we) |-> !(wr_f.en || wr_g.en);
    endproperty
    a_async_we_low: assert property (p_async_we_low) else $error("async write without we");

    // limitation: a wclk pulse that comes and goes while frozen is lost
    property p_ce_freeze;
        @(posedge i_clk) disable iff (i_srst)
        !i_ce |=> (wclk_s2_q == $past(wclk_s2_q)) && (wclk_s3_q == $past(wclk_s3_q));
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("edge history moved while frozen");

    property p_one_write_per_edge;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && !async_eff && wr_strobe) |=> (!edge_hit || $changed(i_wclk_invert));
    endproperty
    a_one_write_per_edge: assert property (p_one_write_per_edge) else $error("edge seen twice");

    property p_single_port_addr;
        @(posedge i_clk) disable iff (i_srst)
        (i_org != org_dual) |-> (raddr_f == wr_f.addr) && (raddr_g == wr_g.addr);
    endproperty
    a_single_port_addr: assert property (p_single_port_addr) else $error("read and write address differ");

    property p_logic_f_readback;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_org == org_ram_logic && wr_f.en) ##1 (i_org == org_ram_logic && i_addr_f == $past(i_addr_f))
            |-> o_first_read_output == $past(i_primary_data_in);
    endproperty
    a_logic_f_readback: assert property (p_logic_f_readback) else $error("ram beside logic readback wrong");

    c_dual_same_addr: cover property (@(posedge i_clk) disable iff (i_srst)
        i_org == org_dual && wr_f.en && i_second_read_address == i_addr_f);
    c_combined_upper: cover property (@(posedge i_clk) disable iff (i_srst)
        i_org == org_combined && wr_g.en);
    c_async_split: cover property (@(posedge i_clk) disable iff (i_srst)
        i_org == org_split && i_async && wr_f.en);
    c_inverted_edge: cover property (@(posedge i_clk) disable iff (i_srst)
        i_wclk_invert && !async_eff && wr_f.en);
    c_dual_diff_addr: cover property (@(posedge i_clk) disable iff (i_srst)
        i_org == org_dual && wr_f.en && i_second_read_address != i_addr_f);
endmodule : lut_distributed_ram

// File: src/lut_ram_pkg.sv
// shared constants and types for the logic-cell lookup table ram
package lut_ram_pkg;
    localparam int unsigned ADDR_W       = 4;
    localparam int unsigned DEPTH        = 16;
    localparam int unsigned LOGIC_IN_W   = 5;
    localparam int unsigned LOGIC_TAB_W  = 32;
    localparam logic        MEM_RST_VAL  = 1'h0;
    localparam logic        WCLK_RST_VAL = 1'h0;

    // organisation of the two lookup tables of one logic_cell
    typedef enum logic [1:0] {
        org_split,
        org_combined,
        org_dual,
        org_ram_logic
    } ram_org_t;

    // write port of one lookup table
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic              data;
    } table_wr_t;
endpackage : lut_ram_pkg

// File: src/lut_table_mem.sv
// one 16x1 lookup table memory with combinational read
`timescale 1ns/1ps
module lut_table_mem
    import lut_ram_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_srst,
    input  wire logic                          i_ce,
    input  wire lut_ram_pkg::table_wr_t        i_wr,
    input  wire logic [lut_ram_pkg::ADDR_W-1:0] i_raddr,
    output logic                               o_rdata
);
    logic [DEPTH-1:0] mem_q;
    logic [DEPTH-1:0] mem_d;

    always_comb begin
        mem_d = mem_q;
        if (i_ce && i_wr.en) begin
            mem_d[i_wr.addr] = i_wr.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mem_q <= {DEPTH{MEM_RST_VAL}};
        end else begin
            mem_q <= mem_d;
        end
    end

    // read is pure lookup, no register in the path, so old data shows until the write edge
    assign o_rdata = mem_q[i_raddr];
endmodule : lut_table_mem

// File: testbench/user_logic_model.sv
// surrounding user logic: write clock, write enable, addresses and data
`timescale 1ns/1ps
module user_logic_model (
    input  wire logic       i_clk,
    output logic            o_wclk,
    output logic            o_we,
    output logic [3:0]      o_addr_f,
    output logic [3:0]      o_addr_g,
    output logic            o_d0,
    output logic            o_d1
);
    initial begin
        {o_wclk, o_we, o_addr_f, o_addr_g, o_d0, o_d1} = '0;
    end
    task automatic addr(input logic [3:0] af, input logic [3:0] ag, input logic d1);
        o_addr_f <= af;
        o_addr_g <= ag;
        o_d1     <= d1;
    endtask : addr
    // idle edge first with we low, then active edge; held long enough for the pin synchroniser
    task automatic wr_sync(input logic inv, input logic [3:0] af, input logic [3:0] ag,
                           input logic d0, input logic d1, input logic we);
        @(posedge i_clk);
        o_wclk <= inv;
        o_we   <= 1'h0;
        repeat (4) @(posedge i_clk);
        o_wclk <= ~inv;
        o_we   <= we;
        addr(af, ag, d1);
        o_d0   <= d0;
        repeat (5) @(posedge i_clk);
        o_we   <= 1'h0;
        o_d0   <= ~d0;
        o_d1   <= ~d1;
    endtask : wr_sync
    // released data lines show the inverse so stale values cannot pass
    task automatic wr_async(input logic [3:0] af, input logic [3:0] ag, input logic d0, input logic d1);
        @(posedge i_clk);
        o_we <= 1'h1;
        addr(af, ag, d1);
        o_d0 <= d0;
        @(posedge i_clk);
        o_we <= 1'h0;
        o_d0 <= ~d0;
        o_d1 <= ~d1;
    endtask : wr_async
endmodule : user_logic_model

// File: testbench/lut_distributed_ram_tb_top.sv
// self-checking bench for the logic-cell lookup table ram
`timescale 1ns/1ps
module lut_distributed_ram_tb_top;
    import lut_ram_pkg::*;
    logic        clk = 1'h0, srst = 1'h1, ce = 1'h1, async_w = 1'h0, inv = 1'h0;
    ram_org_t    org = org_split;
    logic [3:0]  ra2 = 4'h0;
    logic [4:0]  li = 5'h00;
    logic [31:0] tbl = 32'h8000_0025;
    logic        wclk, we, d0, d1, q1, q2;
    logic [3:0]  af, ag;
    int          n_mismatch = 0, tests_run = 0;
    always #5 clk = ~clk;
    user_logic_model m (.i_clk(clk), .o_wclk(wclk), .o_we(we), .o_addr_f(af), .o_addr_g(ag),
                        .o_d0(d0), .o_d1(d1));
    lut_distributed_ram uut (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_org(org), .i_async(async_w),
        .i_wclk_invert(inv), .i_wclk(wclk), .i_we(we), .i_addr_f(af), .i_addr_g(ag),
        .i_second_read_address(ra2), .i_primary_data_in(d0), .i_secondary_data_in(d1),
        .i_logic_inputs(li), .i_logic_table(tbl), .o_first_read_output(q1), .o_second_read_output(q2));
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: read %b expected %b", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // fresh reset per scenario so earlier writes cannot mask a missed one
    task automatic setup(input ram_org_t o, input logic a, input logic v);
        @(posedge clk);
        org     <= o;
        async_w <= a;
        inv     <= v;
        srst    <= 1'h1;
        repeat (2) @(posedge clk);
        srst    <= 1'h0;
    endtask : setup
    // outputs judged in the same cycle the address lands
    task automatic rd(input logic [3:0] a, input logic [3:0] g, input logic h, input logic [3:0] b,
                      input logic e1, input logic e2);
        @(posedge clk);
        m.addr(a, g, h);
        ra2 <= b;
        #1;
        chk(q1, e1);
        chk(q2, e2);
    endtask : rd
    task automatic t_split();
        setup(org_split, 1'h0, 1'h0);
        m.wr_sync(1'h0, 4'h3, 4'h5, 1'h1, 1'h1, 1'h1);
        rd(4'h3, 4'h5, 1'h0, 4'h0, 1'h1, 1'h1);
        rd(4'h5, 4'h3, 1'h0, 4'h0, 1'h0, 1'h0);
        m.wr_async(4'h3, 4'h5, 1'h0, 1'h0);
        m.wr_sync(1'h0, 4'h3, 4'h5, 1'h0, 1'h0, 1'h0);
        rd(4'h3, 4'h5, 1'h0, 4'h0, 1'h1, 1'h1);
        m.wr_sync(1'h0, 4'h9, 4'h9, 1'h1, 1'h0, 1'h1);
        rd(4'h9, 4'h9, 1'h0, 4'h0, 1'h1, 1'h0);
        @(posedge clk);
        ce <= 1'h0;
        m.wr_sync(1'h0, 4'h1, 4'h1, 1'h1, 1'h1, 1'h1);
        rd(4'h1, 4'h1, 1'h0, 4'h0, 1'h0, 1'h0);
        @(posedge clk);
        ce <= 1'h1;
    endtask : t_split
    task automatic t_modes();
        setup(org_split, 1'h1, 1'h0);
        m.wr_async(4'h2, 4'h6, 1'h1, 1'h1);
        rd(4'h2, 4'h6, 1'h0, 4'h0, 1'h1, 1'h1);
        @(posedge clk);
        ce <= 1'h0;
        m.wr_async(4'h3, 4'h6, 1'h1, 1'h0);
        rd(4'h3, 4'h6, 1'h0, 4'h0, 1'h0, 1'h1);
        @(posedge clk);
        ce <= 1'h1;
        setup(org_combined, 1'h0, 1'h0);
        m.wr_sync(1'h0, 4'h4, 4'h0, 1'h1, 1'h1, 1'h1);
        rd(4'h4, 4'h0, 1'h1, 4'h0, 1'h1, 1'h0);
        rd(4'h4, 4'h0, 1'h0, 4'h0, 1'h0, 1'h0);
        setup(org_dual, 1'h1, 1'h0);
        m.wr_async(4'h7, 4'h0, 1'h1, 1'h0);
        rd(4'h7, 4'h0, 1'h0, 4'h7, 1'h0, 1'h0);
        m.wr_sync(1'h0, 4'h7, 4'h0, 1'h1, 1'h0, 1'h1);
        rd(4'h7, 4'h0, 1'h0, 4'h7, 1'h1, 1'h1);
        rd(4'h8, 4'h0, 1'h0, 4'h7, 1'h0, 1'h1);
        m.wr_sync(1'h0, 4'h3, 4'h0, 1'h1, 1'h0, 1'h1);
        rd(4'h3, 4'h0, 1'h0, 4'h7, 1'h1, 1'h1);
        rd(4'h8, 4'h0, 1'h0, 4'h3, 1'h0, 1'h1);
    endtask : t_modes
    task automatic t_inv_logic();
        setup(org_split, 1'h0, 1'h1);
        m.wr_sync(1'h0, 4'h1, 4'h1, 1'h1, 1'h1, 1'h1);
        rd(4'h1, 4'h1, 1'h0, 4'h0, 1'h0, 1'h0);
        m.wr_sync(1'h1, 4'h1, 4'h1, 1'h1, 1'h1, 1'h1);
        rd(4'h1, 4'h1, 1'h0, 4'h0, 1'h1, 1'h1);
        setup(org_ram_logic, 1'h0, 1'h0);
        m.wr_sync(1'h0, 4'h2, 4'h0, 1'h1, 1'h0, 1'h1);
        rd(4'h2, 4'h0, 1'h0, 4'h0, 1'h1, tbl[0]);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            li <= 5'(i);
            #1;
            chk(q1, 1'h1);
            chk(q2, tbl[i]);
        end
    endtask : t_inv_logic
    task automatic t_clear_read();
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), 4'(i), 1'h0, 4'(i), 1'h0, 1'h0);
        end
    endtask : t_clear_read
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        t_clear_read();
        t_split();
        t_modes();
        t_inv_logic();
        complete_run();
    end
    // a hang counts as a failure; the whole run needs well under this
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule : lut_distributed_ram_tb_top
